// ---- bench/nvi_core_model.sv ----
// Purpose: Core-side model that accepts interrupt offers
// Assumes: An offer holds until it is acknowledged or withdrawn
// Notes:   Acknowledge delay and willingness are set by the bench
`timescale 1ns/1ns
`default_nettype none
module nvi_core_model (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire nvi_pkg::nvi_take_t takeReq,
    input  wire logic               ackOn,
    input  wire logic [3:0]         ackDelay,
    output logic                    takeAck,
    output logic [7:0]              lastVec,
    output logic [31:0]             lastAddr
);
    logic [3:0] waitCnt;
    // Count offer cycles, then pulse acknowledge once and note the vector
    always_ff @(posedge mclk) begin
        if (srst) begin
            takeAck  <= 1'b0;
            waitCnt  <= 4'h0;
            lastVec  <= 8'h00;
            lastAddr <= 32'h0000_0000;
        end else begin
            takeAck <= 1'b0;
            if (ackOn && takeReq.valid && !takeAck) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt >= ackDelay) begin
                    takeAck  <= 1'b1;
                    waitCnt  <= 4'h0;
                    lastVec  <= takeReq.vecNum;
                    lastAddr <= takeReq.vecAddr;
                end
            end else begin
                waitCnt <= 4'h0; // Withdrawn offer restarts the wait
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/vectored_interrupt_enable_pend_logic_test.sv ----
// Purpose: Self-checking bench for the interrupt state unit
// Assumes: Core model acknowledges offers after a set delay
// Notes:   Inputs change by non-blocking assignment at rising edges, except ackOn and ackDelay, set 1 ns after an edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module vectored_interrupt_enable_pend_logic_test;
    logic                  mclk = 1'b0;
    logic                  srst = 1'b1;
    logic [31:0]           irqReq = 32'h0;
    nvi_pkg::nvi_w1_t      w1s = '0;
    nvi_pkg::nvi_prio_wr_t prioWr = '0;
    logic [31:0]           excRet = 32'h0;
    logic                  ackOn = 1'b0;
    logic [3:0]            ackDelay = 4'h0;
    logic                  takeAck;
    logic [31:0]           enableState, pendState, activeState, mspAddr, lastAddr;
    logic [255:0]          prioState;
    logic [7:0]            lastVec;
    nvi_pkg::nvi_take_t    takeReq;
    int                    fails = 0;
    int                    checks = 0;

    nvi_core nvi_core_i (.mclk(mclk), .srst(srst), .irqReq(irqReq), .w1Strobe(w1s),
        .prioWr(prioWr), .takeAck(takeAck), .excReturn(excRet), .enableState(enableState),
        .pendState(pendState), .activeState(activeState), .prioState(prioState),
        .takeReq(takeReq), .mainStackPtrAddr(mspAddr));
    nvi_core_model nvi_core_model_i (.mclk(mclk), .srst(srst), .takeReq(takeReq),
        .ackOn(ackOn), .ackDelay(ackDelay), .takeAck(takeAck), .lastVec(lastVec),
        .lastAddr(lastAddr));

    // Clock at 100 MHz
    always #5 mclk = ~mclk;

    // One write-one pulse; returns once the new state has landed
    task automatic pulse(input int k, input logic [31:0] m);
        @(posedge mclk);
        case (k)
            0: w1s.setEnable <= m;
            1: w1s.clrEnable <= m;
            2: w1s.setPend <= m;
            default: w1s.clrPend <= m;
        endcase
        @(posedge mclk);
        w1s <= '0;
        #1;
    endtask

    // Bounded wait for a line to turn active
    task automatic wait_active(input int n);
        for (int i = 0; i < 20 && activeState[n] !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic t_reset;
        `CHK("enable", 32'h0, enableState)
        `CHK("pend", 32'h0, pendState)
        `CHK("active", 32'h0, activeState)
        `CHK("offer", 1'b0, takeReq.valid)
        `CHK("msp", 32'h0, mspAddr)
    endtask

    task automatic t_enable;
        pulse(0, 32'h0000_00f0);
        pulse(0, 32'h0000_000f);
        `CHK("enable", 32'h0000_00ff, enableState)
        pulse(1, 32'h0000_0030);
        `CHK("enable", 32'h0000_00cf, enableState)
        pulse(1, 32'hffff_ffff);
        `CHK("enable", 32'h0, enableState)
    endtask

    task automatic t_pend_disabled;
        @(posedge mclk);
        irqReq[9] <= 1'b1;
        @(posedge mclk);
        irqReq[9] <= 1'b0;
        pulse(2, 32'h0000_0100);
        repeat (5) @(posedge mclk);
        #1;
        `CHK("pend", 32'h0000_0300, pendState)
        `CHK("offer", 1'b0, takeReq.valid)
        `CHK("active", 32'h0, activeState)
        pulse(3, 32'h0000_0300);
        `CHK("pend", 32'h0, pendState)
    endtask

    task automatic t_take;
        ackOn <= 1'b1;
        ackDelay <= 4'h3;
        pulse(2, 32'h0000_0010);
        pulse(0, 32'h0000_0010);
        wait_active(4);
        `CHK("active", 32'h0000_0010, activeState)
        `CHK("pend", 32'h0, pendState)
        `CHK("vector", 8'd20, lastVec)
        `CHK("handler", 32'h0000_0050, lastAddr)
        pulse(1, 32'h0000_0010);
        pulse(2, 32'h0000_0010);
        pulse(3, 32'h0000_0010);
        `CHK("active", 32'h0000_0010, activeState)
        @(posedge mclk);
        excRet <= 32'h0000_0010;
        @(posedge mclk);
        excRet <= 32'h0;
        #1;
        `CHK("active", 32'h0, activeState)
    endtask

    task automatic t_prio;
        ackOn <= 1'b0;
        ackDelay <= 4'h0;
        @(posedge mclk);
        prioWr <= '{1'b1, 3'd1, 4'b0110, 32'h0040_8000};
        @(posedge mclk);
        prioWr <= '0;
        #1;
        `CHK("prio", 32'h0040_8000, prioState[63:32])
        pulse(2, 32'h0000_0060);
        pulse(0, 32'h0000_0060);
        for (int i = 0; i < 20 && takeReq.valid !== 1'b1; i++) @(posedge mclk);
        #1;
        `CHK("winner", 5'd6, takeReq.irq)
        ackOn <= 1'b1;
        wait_active(5);
        `CHK("active", 32'h0000_0060, activeState)
        `CHK("vector", 8'd21, lastVec)
        @(posedge mclk);
        excRet <= 32'h0000_0060;
        @(posedge mclk);
        excRet <= 32'h0;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_enable();
        t_pend_disabled();
        t_take();
        t_prio();
        test_done();
    end

    // Watchdog well past the expected run of under a hundred cycles
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire

// ---- rtl/nvi_arbiter.sv ----
// Purpose: Pick the highest-priority enabled pending line
// Assumes: Lower field value means more urgent, ties to lower index
// Notes:   Only the top two priority bits count, giving four levels
`timescale 1ns/1ns
`default_nettype none
module nvi_arbiter (
    input  wire logic [31:0]  cand,
    input  wire logic [255:0] prioFlat,
    output logic              found,
    output logic [4:0]        winIdx
);
    logic [1:0] bestLvl;
    logic [1:0] lvl;

    // Linear scan keeping the first best level
    always_comb begin
        found   = 1'b0;
        winIdx  = 5'h00;
        bestLvl = 2'h3;
        lvl     = 2'h0;
        for (int i = 0; i < nvi_pkg::NUM_IRQ; i++) begin
            lvl = prioFlat[i*nvi_pkg::PRIO_W + nvi_pkg::PRIO_USED_LSB +: 2];
            if (cand[i] && (!found || lvl < bestLvl)) begin
                found   = 1'b1;
                bestLvl = lvl;
                winIdx  = 5'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/nvi_core.sv ----
// Purpose: Enable, pending, active and priority state of the interrupt unit
// Assumes: Core acknowledges activation and signals exception return per line
// Notes:   Vector addresses are formed from the fixed table base
// Contract
// - Set-enable and clear-enable write ones; zeros ignored; both read enable state
// - Request on a disabled line pends it but does not activate it; requests are ignored while the line is active
// - Active line stays active when disabled until reset or exception return
// - Disabled line never starts a new activation
// - Set-pending and clear-pending write ones; both read pending state
// - Clear-pending leaves an active line active
// - Each line has an 8-bit priority, four per 32-bit word
// - Table entry zero supplies the initial main stack pointer
// - Other entries hold handler addresses indexed by vector number
// - Enable, pending and priority state reachable as control space
// - Thirty-two request inputs with four priority levels each
// - Vector table base fixed at zero, no relocation
// - Accepted interrupt fetches its handler address from the table
`timescale 1ns/1ns
`default_nettype none
module nvi_core (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic [31:0]          irqReq,
    input  wire nvi_pkg::nvi_w1_t     w1Strobe,
    input  wire nvi_pkg::nvi_prio_wr_t prioWr,
    input  wire logic                 takeAck,
    input  wire logic [31:0]          excReturn,
    output logic [31:0]               enableState,
    output logic [31:0]               pendState,
    output logic [31:0]               activeState,
    output logic [255:0]              prioState,
    output nvi_pkg::nvi_take_t        takeReq,
    output logic [31:0]               mainStackPtrAddr
);
    logic [31:0]  enableReg;
    logic [31:0]  enableNext;
    logic [31:0]  pendReg;
    logic [31:0]  pendNext;
    logic [31:0]  activeReg;
    logic [31:0]  activeNext;
    logic [255:0] prioReg;
    logic [255:0] prioNext;
    logic [31:0]  hwPend;
    logic [31:0]  cand;
    logic         found;
    logic [4:0]   winIdx;
    nvi_pkg::nvi_take_t takeReg;
    nvi_pkg::nvi_take_t takeNext;

    // Vector table address of an entry number
    function automatic logic [31:0] vec_addr(input logic [7:0] num);
        vec_addr = nvi_pkg::VTOR_BASE + {22'h000000, num, 2'h0};
    endfunction

    // Per-line request capture
    genvar g;
    generate
        for (g = 0; g < nvi_pkg::NUM_IRQ; g++) begin : gLine
            nvi_edge_latch nvi_edge_latch_i (
                .mclk    (mclk),
                .srst    (srst),
                .reqIn   (irqReq[g]),
                .pendSet (hwPend[g])
            );
        end
    endgenerate

    // Only enabled, pending, idle lines compete; an outstanding offer does not mask them
    assign cand = enableReg & pendReg & ~activeReg;

    nvi_arbiter nvi_arbiter_i (
        .cand     (cand),
        .prioFlat (prioReg),
        .found    (found),
        .winIdx   (winIdx)
    );

    // Enable bits: set wins over clear
    always_comb begin
        enableNext = (enableReg & ~w1Strobe.clrEnable) | w1Strobe.setEnable;
    end

    // Pending, active and offer state
    always_comb begin
        pendNext   = pendReg;
        activeNext = activeReg;
        takeNext   = takeReg;
        // Exception return is the only way out of active, besides reset
        activeNext = activeNext & ~excReturn;
        // Clear-pending touches pending only, never active
        pendNext   = pendNext & ~w1Strobe.clrPend;
        // Software sets, and hardware sets on lines not active, win over clear, regardless of enable
        pendNext   = pendNext | w1Strobe.setPend | (hwPend & ~activeReg);
        // A stale acknowledge on a line disabled meanwhile never activates it
        if (takeReg.valid && takeAck && enableReg[takeReg.irq]) begin
            activeNext[takeReg.irq] = 1'b1;
            pendNext[takeReg.irq]   = w1Strobe.setPend[takeReg.irq];
            takeNext.valid          = 1'b0;
        end else if (!takeReg.valid && found) begin
            takeNext.valid   = 1'b1;
            takeNext.irq     = winIdx;
            takeNext.vecNum  = 8'(nvi_pkg::EXT_VEC_BASE) + {3'h0, winIdx};
            takeNext.vecAddr = vec_addr(8'(nvi_pkg::EXT_VEC_BASE) + {3'h0, winIdx});
        end
        // Withdraw offer if the line got disabled before acceptance
        if (takeReg.valid && !enableReg[takeReg.irq]) begin
            takeNext.valid = 1'b0;
        end
    end

    // Priority fields with byte lanes
    always_comb begin
        prioNext = prioReg;
        if (prioWr.wrEn) begin
            for (int b = 0; b < nvi_pkg::PRIO_PER_WORD; b++) begin
                if (prioWr.byteEn[b]) begin
                    prioNext[(32*prioWr.wordIdx) + 8*b +: 8] = prioWr.wrData[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            enableReg <= nvi_pkg::RST_ZERO32;
            pendReg   <= nvi_pkg::RST_ZERO32;
            activeReg <= nvi_pkg::RST_ZERO32;
            prioReg   <= {nvi_pkg::NUM_IRQ{nvi_pkg::RST_PRIO}};
            takeReg   <= '0;
        end else begin
            enableReg <= enableNext;
            pendReg   <= pendNext;
            activeReg <= activeNext;
            prioReg   <= prioNext;
            takeReg   <= takeNext;
        end
    end

    // State readback for the control space
    assign enableState      = enableReg;
    assign pendState        = pendReg;
    assign activeState      = activeReg;
    assign prioState        = prioReg;
    assign takeReq          = takeReg;
    assign mainStackPtrAddr = nvi_pkg::VTOR_BASE + nvi_pkg::MSP_ENTRY_OFS;

    // Checks
    a_w1_enable_set : assert property (@(posedge mclk) disable iff (srst)
        w1Strobe.setEnable[0] |=> enableState[0]) else $error("enable set lost");
    a_w1_enable_clr : assert property (@(posedge mclk) disable iff (srst)
        w1Strobe.clrEnable[3] && !w1Strobe.setEnable[3] |=> !enableState[3])
        else $error("enable clear lost");
    a_disabled_pends : assert property (@(posedge mclk) disable iff (srst)
        hwPend[9] && !activeState[9] && !enableState[9] |=> pendState[9] && !activeState[9])
        else $error("disabled line not pended");
    a_active_holds : assert property (@(posedge mclk) disable iff (srst)
        activeState[4] && !excReturn[4] |=> activeState[4]) else $error("active dropped");
    a_no_offer_disabled : assert property (@(posedge mclk) disable iff (srst)
        $rose(takeReq.valid) |-> $past(enableState[winIdx]))
        else $error("offer on disabled line");
    a_pend_set : assert property (@(posedge mclk) disable iff (srst)
        w1Strobe.setPend[4] |=> pendState[4]) else $error("pend set lost");
    sequence s_offer_taken;
        takeReq.valid && takeAck;
    endsequence
    a_take_activates : assert property (@(posedge mclk) disable iff (srst)
        s_offer_taken |=> activeState[$past(takeReq.irq)]) else $error("no activation");
    a_vector_addr : assert property (@(posedge mclk) disable iff (srst)
        takeReq.valid |-> takeReq.vecAddr == {22'h000000, takeReq.vecNum, 2'h0})
        else $error("bad vector address");
    a_prio_write : assert property (@(posedge mclk) disable iff (srst)
        prioWr.wrEn && prioWr.wordIdx == 3'h1 && prioWr.byteEn[1]
        |=> prioState[47:40] == $past(prioWr.wrData[15:8])) else $error("prio lost");
endmodule
`default_nettype wire

// ---- rtl/nvi_edge_latch.sv ----
// Purpose: Request line capture for one interrupt input
// Assumes: Request lines are synchronous to mclk
// Notes:   Level lines re-pend while held; pulses pend on the rising edge
`timescale 1ns/1ns
`default_nettype none
module nvi_edge_latch (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic reqIn,
    output logic      pendSet
);
    logic lastReg;
    logic lastNext;

    // Track previous level
    always_comb begin
        lastNext = reqIn;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lastReg <= 1'b0;
        end else begin
            lastReg <= lastNext;
        end
    end

    // Pends whenever the request is high; lastReg drops out, so a held level pends every cycle
    assign pendSet = reqIn & (~lastReg | reqIn);
endmodule
`default_nettype wire

// ---- rtl/nvi_pkg.sv ----
// Purpose: Shared constants and carriers for the vectored interrupt unit
// Assumes: 32 request lines, 8-bit priority fields packed four to a word
// Notes:   Vector table base is fixed at zero
package nvi_pkg;
    localparam int          NUM_IRQ       = 32;
    localparam int          PRIO_W        = 8;
    localparam int          PRIO_PER_WORD = 4;
    localparam int          PRIO_WORDS    = NUM_IRQ / PRIO_PER_WORD;
    localparam int          IDX_W         = 5;
    localparam int          EXT_VEC_BASE  = 16;
    localparam logic [31:0] VTOR_BASE     = 32'h0000_0000;
    localparam logic [31:0] MSP_ENTRY_OFS = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO32    = 32'h0000_0000;
    localparam logic [7:0]  RST_PRIO      = 8'h00;
    localparam int          PRIO_USED_MSB = 7;
    localparam int          PRIO_USED_LSB = 6;

    // Per-line write-one strobes from software
    typedef struct packed {
        logic [31:0] setEnable;
        logic [31:0] clrEnable;
        logic [31:0] setPend;
        logic [31:0] clrPend;
    } nvi_w1_t;

    // Priority word write
    typedef struct packed {
        logic        wrEn;
        logic [2:0]  wordIdx;
        logic [3:0]  byteEn;
        logic [31:0] wrData;
    } nvi_prio_wr_t;

    // Activation request to the core
    typedef struct packed {
        logic        valid;
        logic [4:0]  irq;
        logic [7:0]  vecNum;
        logic [31:0] vecAddr;
    } nvi_take_t;
endpackage
